/* File: clcd_pkg.sv */
// package: constants and types for the character display instruction decoder
package clcd_pkg;
  localparam int CLCD_CLK_HZ = 50_000_000;
  // instruction execution time in ns, as printed for the slowest oscillator setting
  localparam int CLCD_EXEC_NS = 26300;
  localparam int CLCD_EXEC_CYC = (CLCD_EXEC_NS * (CLCD_CLK_HZ / 1_000_000) + 999) / 1000;
  // register byte addresses
  localparam logic [11:0] CLCD_OFS_CMD = 12'h000;
  localparam logic [11:0] CLCD_OFS_DATA = 12'h004;
  localparam logic [11:0] CLCD_OFS_STAT = 12'h008;
  localparam logic [11:0] CLCD_OFS_CFG = 12'h00c;
  localparam logic [11:0] CLCD_OFS_ANALOG = 12'h010;
  localparam logic [11:0] CLCD_OFS_PINS = 12'h014;
  // address ranges of display, glyph and icon ram
  localparam logic [6:0] CLCD_DD_1L_MAX = 7'h4f;
  localparam logic [6:0] CLCD_DD_L1_MAX = 7'h27;
  localparam logic [6:0] CLCD_DD_L2_MIN = 7'h40;
  localparam logic [6:0] CLCD_DD_L2_MAX = 7'h67;
  localparam logic [6:0] CLCD_ICON_MAX = 7'h0f;
  localparam logic [6:0] CLCD_GLYPH_MAX = 7'h3f;
  // memory base in a shared 8-bit storage of 256 bytes
  localparam logic [7:0] CLCD_BASE_DD = 8'h00;
  localparam logic [7:0] CLCD_BASE_GL = 8'h80;
  localparam logic [7:0] CLCD_BASE_IC = 8'hc0;
  // reset values
  localparam logic CLCD_RST_INC = 1'b1;
  localparam logic CLCD_RST_LINES = 1'b0;
  localparam logic CLCD_RST_TABLE = 1'b0;
  localparam logic [2:0] CLCD_RST_TRIM = 3'h4;
  localparam logic [2:0] CLCD_RST_GAIN = 3'h2;
  localparam logic [5:0] CLCD_RST_CONTRAST = 6'h20;
  typedef enum logic [2:0] {
    CLCD_TGT_DD = 3'b001,
    CLCD_TGT_GL = 3'b010,
    CLCD_TGT_IC = 3'b100
  } clcd_tgt_t;
  typedef enum logic [3:0] {
    CLCD_ST_IDLE = 4'b0001,
    CLCD_ST_EXEC = 4'b0010,
    CLCD_ST_RAMW = 4'b0100,
    CLCD_ST_RAMR = 4'b1000
  } clcd_state_t;
endpackage

/* File: clcd_mem_if.sv */
// interface: port between decoder and its data memory
`timescale 1ns/1ps
interface clcd_mem_if;
  logic we;
  logic re;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

/* File: clcd_ram.sv */
// module: byte memory holding display, glyph and icon data
`timescale 1ns/1ps
module clcd_ram #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  clcd_mem_if.mem port
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rd_r;
  // the decoder maps three regions into exactly 256 bytes
  if (DEPTH != 256) begin : g_depth_chk
    $error("clcd_ram depth must be 256");
  end
  // write port, no reset on storage
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
  end
  // registered read data
  always_ff @(posedge clk_i) begin
    if (port.re) begin
      rd_r <= mem_r[port.addr];
    end
  end
  assign port.rdata = rd_r;
endmodule // clcd_ram

/* File: clcd_core.sv */
// module: instruction decoder with ahb-lite register access
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
// What this block does
// [RQ1] high-bit command loads counter, targets display ram
// [RQ2] single-line display addresses 00h to 4fh
// [RQ3] two-line: 00h-27h first, 40h-67h second
// [RQ4] status read: busy on bit7, counter below
// [RQ5] host waits while busy before new instruction
// [RQ6] counter steps one after every data access
// [RQ7] data write stores byte into selected ram
// [RQ8] data read returns byte from selected ram
// [RQ9] first read without address set is invalid
// [RQ10] bias select: high quarter, low fifth
// [RQ11] bias ignored with both follower pins high
// [RQ12] trim code adjusts oscillator when clock pin high
// [RQ13] icon address loads four bits, selects icon
// [RQ14] icon enable bit switches icon display
// [RQ15] booster enable only under internal follower
// [RQ16] contrast split: two high, four low bits
// [RQ17] follower enable only under internal follower
// [RQ18] gain ratio only under internal follower
// [RQ19] extended commands only when table select high
// [RQ20] line select high means two lines
// [RQ21] step direction high increments, low decrements
// [RQ22] data read uses register select high
module clcd_core
  import clcd_pkg::*;
#(
  parameter int EXEC_CYC = CLCD_EXEC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic follower_option_pin_a_i,
  input wire logic follower_option_pin_b_i,
  input wire logic clock_source_select_i,
  output logic bias_quarter_o,
  output logic [2:0] osc_trim_code_o,
  output logic icon_on_o,
  output logic booster_on_o,
  output logic follower_on_o,
  output logic [2:0] gain_ratio_o,
  output logic [5:0] contrast_code_o,
  output logic two_line_o
);
  // refuse counts that the 12-bit execution timer cannot hold
  if (EXEC_CYC < 2 || EXEC_CYC > 4095) begin : g_exec_chk
    $error("clcd_core exec count out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {clock_source_select_i, follower_option_pin_b_i, follower_option_pin_a_i};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic ext_bias;
  logic int_follower;
  logic clk_src_hi;
  assign ext_bias = pin_s2_r[0] & pin_s2_r[1];
  assign int_follower = ~pin_s2_r[0] & ~pin_s2_r[1];
  assign clk_src_hi = pin_s2_r[2];
  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  logic ph_act_r;
  logic ph_wr_r;
  logic [11:0] ph_addr_r;
  logic busy_r;
  clcd_state_t state_r;
  logic stall;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ph_act_r <= 1'b0;
      ph_wr_r <= 1'b0;
      ph_addr_r <= 12'h000;
    end else if (hreadyout_o) begin
      ph_act_r <= hsel_i & htrans_i[1] & hready_i;
      ph_wr_r <= hwrite_i;
      ph_addr_r <= haddr_i[11:0];
    end
  end
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  assign cmd_wr = ph_act_r & ph_wr_r & (ph_addr_r == CLCD_OFS_CMD);
  assign data_wr = ph_act_r & ph_wr_r & (ph_addr_r == CLCD_OFS_DATA);
  assign data_rd = ph_act_r & ~ph_wr_r & (ph_addr_r == CLCD_OFS_DATA); // see [RQ22]
  // a data read waits for the registered memory output
  assign stall = data_rd & (state_r != CLCD_ST_RAMR);
  assign hreadyout_o = ~stall;
  assign hresp_o = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic inc_r;
  logic lines_r;
  logic table_r;
  logic bias_r;
  logic [2:0] trim_r;
  logic icon_r;
  logic boost_r;
  logic fol_r;
  logic [2:0] gain_r;
  logic [5:0] con_r;
  logic [6:0] ac_r;
  clcd_tgt_t tgt_r;
  logic primed_r;
  logic [7:0] cmd;
  logic accept;
  assign cmd = hwdata_i[7:0];
  // commands written while busy are dropped; software must poll first
  assign accept = cmd_wr & ~busy_r; // see [RQ5]
  function automatic logic [6:0] clcd_step(input logic [6:0] a, input logic up,
                                           input clcd_tgt_t t, input logic two);
    logic [6:0] n;
    n = up ? a + 7'h01 : a - 7'h01; // see [RQ21]
    if (t == CLCD_TGT_IC) begin
      n = n & CLCD_ICON_MAX;
    end else if (t == CLCD_TGT_GL) begin
      n = n & CLCD_GLYPH_MAX;
    end else if (!two) begin
      if (up && a == CLCD_DD_1L_MAX) n = 7'h00; // see [RQ2]
      else if (!up && a == 7'h00) n = CLCD_DD_1L_MAX;
    end else begin
      if (up && a == CLCD_DD_L1_MAX) n = CLCD_DD_L2_MIN; // see [RQ3]
      else if (up && a == CLCD_DD_L2_MAX) n = 7'h00;
      else if (!up && a == CLCD_DD_L2_MIN) n = CLCD_DD_L1_MAX;
      else if (!up && a == 7'h00) n = CLCD_DD_L2_MAX;
    end
    return n;
  endfunction
  // instruction decode of configuration commands
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      inc_r <= CLCD_RST_INC;
      lines_r <= CLCD_RST_LINES;
      table_r <= CLCD_RST_TABLE;
      bias_r <= 1'b0;
      trim_r <= CLCD_RST_TRIM;
      icon_r <= 1'b0;
      boost_r <= 1'b0;
      fol_r <= 1'b0;
      gain_r <= CLCD_RST_GAIN;
      con_r <= CLCD_RST_CONTRAST;
    end else if (accept) begin
      if (cmd[7:2] == 6'b000001) begin
        inc_r <= cmd[1]; // see [RQ21]
      end else if (cmd[7:5] == 3'b001) begin
        lines_r <= cmd[3]; // see [RQ20]
        table_r <= cmd[0];
      end else if (table_r && cmd[7:4] == 4'b0001) begin
        bias_r <= cmd[3]; // see [RQ10] [RQ19]
        if (clk_src_hi) trim_r <= cmd[2:0]; // see [RQ12]
      end else if (table_r && cmd[7:4] == 4'b0101) begin
        icon_r <= cmd[3]; // see [RQ14]
        if (int_follower) boost_r <= cmd[2]; // see [RQ15]
        if (int_follower) con_r[5:4] <= cmd[1:0]; // see [RQ16]
      end else if (table_r && cmd[7:4] == 4'b0110 && int_follower) begin
        fol_r <= cmd[3]; // see [RQ17]
        gain_r <= cmd[2:0]; // see [RQ18]
      end else if (table_r && cmd[7:4] == 4'b0111 && int_follower) begin
        con_r[3:0] <= cmd[3:0]; // see [RQ16]
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // address counter and target selection
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ac_r <= 7'h00;
      tgt_r <= CLCD_TGT_DD;
      primed_r <= 1'b0;
    end else if (accept && cmd[7]) begin
      ac_r <= cmd[6:0]; // see [RQ1]
      tgt_r <= CLCD_TGT_DD;
      primed_r <= 1'b1;
    end else if (accept && cmd[7:6] == 2'b01 && !table_r) begin
      ac_r <= {1'b0, cmd[5:0]};
      tgt_r <= CLCD_TGT_GL;
      primed_r <= 1'b1;
    end else if (accept && table_r && cmd[7:4] == 4'b0100) begin
      ac_r <= {3'h0, cmd[3:0]}; // see [RQ13]
      tgt_r <= CLCD_TGT_IC;
      primed_r <= 1'b1;
    end else if (data_wr || (data_rd && state_r == CLCD_ST_RAMR)) begin
      ac_r <= clcd_step(ac_r, inc_r, tgt_r, lines_r); // see [RQ6]
      if (data_rd) primed_r <= 1'b1; // see [RQ9]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // execution timer and sequencing
  logic [11:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= CLCD_ST_IDLE;
      cnt_r <= 12'h000;
    end else begin
      case (state_r)
        CLCD_ST_IDLE: begin
          if (accept) begin
            state_r <= CLCD_ST_EXEC;
            cnt_r <= 12'(EXEC_CYC - 1);
          end else if (data_rd) begin
            state_r <= CLCD_ST_RAMR;
          end
        end
        CLCD_ST_EXEC: begin
          if (cnt_r == 12'h000) state_r <= CLCD_ST_IDLE;
          else cnt_r <= cnt_r - 12'h001;
        end
        CLCD_ST_RAMR: state_r <= CLCD_ST_IDLE;
        default: state_r <= CLCD_ST_IDLE;
      endcase
    end
  end
  assign busy_r = (state_r == CLCD_ST_EXEC);
  ////////////////////////////////////////////////////////////////////////////
  // data memory
  clcd_mem_if mif ();
  logic [7:0] base;
  always_comb begin
    base = CLCD_BASE_DD;
    if (tgt_r == CLCD_TGT_GL) base = CLCD_BASE_GL;
    else if (tgt_r == CLCD_TGT_IC) base = CLCD_BASE_IC;
  end
  assign mif.we = data_wr; // see [RQ7]
  assign mif.re = data_rd & (state_r == CLCD_ST_IDLE); // see [RQ8]
  assign mif.addr = base | {1'b0, ac_r};
  assign mif.wdata = hwdata_i[7:0];
  clcd_ram #(.DEPTH(256)) u_ram (
    .clk_i(clk_i),
    .port(mif.mem)
  );
  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (ph_addr_r == CLCD_OFS_CMD) begin
      hrdata_o = {24'h0, busy_r, ac_r}; // see [RQ4]
    end else if (ph_addr_r == CLCD_OFS_DATA) begin
      // unprimed first read gives zero instead of stale data
      hrdata_o = primed_r ? {24'h0, mif.rdata} : 32'h0; // see [RQ9]
    end else if (ph_addr_r == CLCD_OFS_STAT) begin
      hrdata_o = {21'h0, tgt_r, busy_r, ac_r};
    end else if (ph_addr_r == CLCD_OFS_CFG) begin
      hrdata_o = {29'h0, table_r, lines_r, inc_r};
    end else if (ph_addr_r == CLCD_OFS_ANALOG) begin
      hrdata_o = {12'h0, con_r, gain_r, fol_r, boost_r, icon_r, trim_r, bias_r, 4'h0};
    end else if (ph_addr_r == CLCD_OFS_PINS) begin
      hrdata_o = {29'h0, pin_s2_r};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // analog control outputs
  assign bias_quarter_o = bias_r & ~ext_bias; // see [RQ11]
  assign osc_trim_code_o = trim_r;
  assign icon_on_o = icon_r;
  assign booster_on_o = boost_r & int_follower; // see [RQ15]
  assign follower_on_o = fol_r & int_follower; // see [RQ17]
  assign gain_ratio_o = gain_r;
  assign contrast_code_o = con_r;
  assign two_line_o = lines_r;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence addr_cmd_s;
    accept && cmd[7];
  endsequence
  busy_after_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ5]
    accept |=> busy_r [*2]) else $error("busy not raised");
  ac_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ1]
    addr_cmd_s |=> ac_r == $past(cmd[6:0]) && tgt_r == CLCD_TGT_DD)
    else $error("address not loaded");
  one_line_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ2]
    tgt_r == CLCD_TGT_DD && !lines_r && !accept |-> ac_r <= CLCD_DD_1L_MAX || !primed_r)
    else $error("one-line range");
  two_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ3]
    data_wr && !accept && tgt_r == CLCD_TGT_DD && lines_r && inc_r && ac_r == CLCD_DD_L1_MAX
    |=> ac_r == CLCD_DD_L2_MIN) else $error("line wrap");
  stat_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ4]
    ph_addr_r == CLCD_OFS_CMD |-> hrdata_o[7:0] == {busy_r, ac_r})
    else $error("status read");
  step_dn_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ6]
    data_wr && !accept && !inc_r && tgt_r == CLCD_TGT_GL
    |=> ac_r == (($past(ac_r) - 7'h01) & CLCD_GLYPH_MAX)) else $error("step down");
  icon_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ13]
    accept && table_r && cmd[7:4] == 4'b0100 |=> tgt_r == CLCD_TGT_IC && ac_r[6:4] == 3'h0)
    else $error("icon address");
  boost_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ15]
    !int_follower |-> !booster_on_o && !follower_on_o) else $error("follower gate");
  bias_ext_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ11]
    ext_bias |-> !bias_quarter_o) else $error("bias gate");
  read_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ8]
    data_rd && state_r == CLCD_ST_IDLE |-> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait");
  table_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ19]
    accept && !table_r && cmd[7:4] == 4'b0101 |=> $stable(icon_r))
    else $error("table gate");
  // field loads: a gated command must leave its field alone, not half-load it
  bias_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ10]
    accept && table_r && cmd[7:4] == 4'b0001 |=> bias_r == $past(cmd[3]))
    else $error("bias select");
  trim_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ12]
    !clk_src_hi |=> $stable(trim_r))
    else $error("trim gate");
  icon_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ14]
    accept && table_r && cmd[7:4] == 4'b0101 |=> icon_on_o == $past(cmd[3]))
    else $error("icon enable");
  con_split_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ16]
    accept && table_r && cmd[7:4] == 4'b0111 && int_follower
    |=> con_r == {$past(con_r[5:4]), $past(cmd[3:0])}) else $error("contrast split");
  follow_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ17]
    accept && table_r && cmd[7:4] == 4'b0110 && int_follower
    |=> fol_r == $past(cmd[3]) && gain_r == $past(cmd[2:0])) else $error("follower set");
  gain_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ18]
    !int_follower |=> $stable(gain_r) && $stable(fol_r))
    else $error("gain gate");
  lines_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ20]
    accept && cmd[7:5] == 3'b001 |=> two_line_o == $past(cmd[3]))
    else $error("line select");
  step_up_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ21]
    data_wr && !accept && inc_r && tgt_r == CLCD_TGT_IC
    |=> ac_r == (($past(ac_r) + 7'h01) & CLCD_ICON_MAX)) else $error("step up");
  // first read after reset with no address set: zero out, then primed
  sequence rd_first_s;
    data_rd && state_r == CLCD_ST_RAMR && !primed_r;
  endsequence
  unprimed_rd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RQ9]
    rd_first_s |-> hrdata_o == 32'h0000_0000 ##1 primed_r)
    else $error("unprimed read");
endmodule // clcd_core

/* File: clcd_host.sv */
// partner: host processor issuing single-word ahb-lite transfers
`timescale 1ns/1ps
module clcd_host (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  ////////////////////////////////////////
  // bus idle from time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end

  ////////////////////////////////////////
  // one transfer, entered just after a rising edge; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel_o <= 1'b1;
    haddr_o <= {20'h0, a};
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o <= 3'b010;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    // reads invert whatever value the data lines held before, not the write data
    hwdata_o <= wr ? wd : ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
  endtask
endmodule // clcd_host

/* File: clcd_core_bench.sv */
// testbench: instruction decoder driven through the host model
`timescale 1ns/1ps
module clcd_core_bench;
  import clcd_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [2:0] pins; logic [16:0] exp;} clcd_row_t;
  localparam int EXEC = 20;
  logic clk_i, rst_b_i, hsel, hwrite, hreadyout, hresp, bias, icon, boost, fol, two;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, pins, trim, gain;
  logic [5:0] con;
  logic [7:0] pat [3] = '{8'h11, 8'h22, 8'h33};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  clcd_row_t rows [14];
  wire logic [16:0] outs = {bias, trim, icon, boost, fol, gain, con, two};

  ////////////////////////////////////////
  // design and host; pins is {clock source, follower b, follower a}
  clcd_core #(.EXEC_CYC(EXEC)) i_clcd_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .follower_option_pin_a_i(pins[0]), .follower_option_pin_b_i(pins[1]),
    .clock_source_select_i(pins[2]), .bias_quarter_o(bias), .osc_trim_code_o(trim),
    .icon_on_o(icon), .booster_on_o(boost), .follower_on_o(fol), .gain_ratio_o(gain),
    .contrast_code_o(con), .two_line_o(two));
  clcd_host i_clcd_host (.clk_i(clk_i), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  // 50 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // hang guard: about thirty commands of some thirty cycles need far less
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////
  // reporting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [16:0] mk(logic b, logic [2:0] t, logic i, logic bo, logic f,
                                     logic [2:0] g, logic [5:0] c, logic tw);
    return {b, t, i, bo, f, g, c, tw};
  endfunction

  ////////////////////////////////////////
  // bus helpers
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    i_clcd_host.xfer(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic chk_rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_clcd_host.xfer(1'b0, a, 32'h0, d);
    check(what, d, exp);
  endtask

  // polls the busy bit; only the hang guard ends a stuck wait
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h80;
    while (s[7] !== 1'b0) i_clcd_host.xfer(1'b0, CLCD_OFS_CMD, 32'h0, s);
  endtask

  task automatic cmd(input logic [7:0] c);
    wait_idle();
    wr(CLCD_OFS_CMD, c);
    wait_idle();
  endtask

  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // pin synchronisers need a few edges to flush
    repeat (3) @(posedge clk_i);
    check("reset outputs", {15'h0, outs}, {15'h0, mk(0, 4, 0, 0, 0, 2, 6'h20, 0)});
    chk_rd("reset config", CLCD_OFS_CFG, 32'h1);
    $display("test reset done");
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    rst_b_i = 1'b0;
    pins = 3'b100;
    rows = '{
      '{8'h21, 3'b100, mk(0, 4, 0, 0, 0, 2, 6'h20, 0)},
      '{8'h1b, 3'b100, mk(1, 3, 0, 0, 0, 2, 6'h20, 0)},
      '{8'h5d, 3'b100, mk(1, 3, 1, 1, 0, 2, 6'h10, 0)},
      '{8'h6d, 3'b100, mk(1, 3, 1, 1, 1, 5, 6'h10, 0)},
      '{8'h7a, 3'b100, mk(1, 3, 1, 1, 1, 5, 6'h1a, 0)},
      '{8'h13, 3'b000, mk(0, 3, 1, 1, 1, 5, 6'h1a, 0)},
      '{8'h70, 3'b011, mk(0, 3, 1, 0, 0, 5, 6'h1a, 0)},
      '{8'h1c, 3'b011, mk(0, 3, 1, 0, 0, 5, 6'h1a, 0)},
      '{8'h64, 3'b011, mk(0, 3, 1, 0, 0, 5, 6'h1a, 0)},
      '{8'h50, 3'b011, mk(0, 3, 0, 0, 0, 5, 6'h1a, 0)},
      '{8'h29, 3'b100, mk(1, 3, 0, 1, 1, 5, 6'h1a, 1)},
      '{8'h28, 3'b100, mk(1, 3, 0, 1, 1, 5, 6'h1a, 1)},
      '{8'h5f, 3'b100, mk(1, 3, 0, 1, 1, 5, 6'h1a, 1)},
      '{8'h1f, 3'b100, mk(1, 3, 0, 1, 1, 5, 6'h1a, 1)}};
    @(posedge clk_i);
    do_reset();
    // pins settle before each command is issued
    foreach (rows[k]) begin
      pins <= rows[k].pins;
      repeat (4) @(posedge clk_i);
      cmd(rows[k].cmd);
      check("extended outputs", {15'h0, outs}, {15'h0, rows[k].exp});
    end
    // register views of the same state: analog fields packed from bit 4 upward
    chk_rd("analog fields", CLCD_OFS_ANALOG, 32'h0006_ae70);
    chk_rd("target and counter", CLCD_OFS_STAT, 32'h0000_021f);
    chk_rd("synced pins", CLCD_OFS_PINS, 32'h0000_0004);
    $display("test command table done");
    // two-line mode: end of first line jumps to start of second
    cmd(8'ha6);
    for (int i = 0; i < 3; i++) wr(CLCD_OFS_DATA, pat[i]);
    chk_rd("counter after writes", CLCD_OFS_CMD, 32'h41);
    cmd(8'ha6);
    for (int i = 0; i < 3; i++) chk_rd("ram byte", CLCD_OFS_DATA, {24'h0, pat[i]});
    // decrementing entry mode, display ram then glyph ram wrapping below zero
    cmd(8'h04);
    cmd(8'h85);
    wr(CLCD_OFS_DATA, 8'h44);
    chk_rd("counter after decrement", CLCD_OFS_CMD, 32'h04);
    cmd(8'h85);
    chk_rd("ram byte", CLCD_OFS_DATA, 32'h44);
    cmd(8'h40);
    wr(CLCD_OFS_DATA, 8'h77);
    chk_rd("glyph decrement", CLCD_OFS_CMD, 32'h3f);
    cmd(8'h06);
    $display("test counter steps done");
    // single line: last address wraps to zero
    cmd(8'h20);
    chk_rd("config", CLCD_OFS_CFG, 32'h1);
    cmd(8'hcf);
    wr(CLCD_OFS_DATA, 8'h55);
    chk_rd("counter after wrap", CLCD_OFS_CMD, 32'h0);
    // glyph ram, then icon ram through the extended table
    cmd(8'h7f);
    wr(CLCD_OFS_DATA, 8'h66);
    chk_rd("glyph counter", CLCD_OFS_CMD, 32'h0);
    cmd(8'h7f);
    chk_rd("glyph byte", CLCD_OFS_DATA, 32'h66);
    cmd(8'h21);
    cmd(8'h4f);
    wr(CLCD_OFS_DATA, 8'h5a);
    chk_rd("icon counter", CLCD_OFS_CMD, 32'h0);
    cmd(8'h4f);
    chk_rd("icon byte", CLCD_OFS_DATA, 32'h5a);
    $display("test ram targets done");
    // a command written while busy is dropped
    wr(CLCD_OFS_CMD, 8'h90);
    chk_rd("busy status", CLCD_OFS_CMD, 32'h90);
    wr(CLCD_OFS_CMD, 8'ha0);
    wait_idle();
    chk_rd("refused command", CLCD_OFS_CMD, 32'h10);
    wr(12'h020, 8'hff);
    chk_rd("unmapped", 12'h020, 32'h0);
    check("response", {31'h0, hresp}, 32'h0);
    $display("test busy and unmapped done");
    // reads with no address set after reset: first one is invalid
    cmd(8'h80);
    wr(CLCD_OFS_DATA, 8'ha5);
    wr(CLCD_OFS_DATA, 8'h3c);
    do_reset();
    chk_rd("first unprimed read", CLCD_OFS_DATA, 32'h0);
    chk_rd("second unprimed read", CLCD_OFS_DATA, 32'h3c);
    $display("test unprimed read done");
    give_verdict();
  end
endmodule // clcd_core_bench
